// File: shared/clk_ctrl_pkg.sv
`default_nettype none
package clk_ctrl_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_MODE = 8'h00;
    localparam logic [7:0] ADDR_OSC  = 8'h04;
    localparam logic [7:0] ADDR_TSEL = 8'h08;
    localparam logic [7:0] ADDR_STAB = 8'h0c;
    localparam logic [7:0] ADDR_IRQ  = 8'h10;
    localparam logic [7:0] ADDR_MASK = 8'h14;
    // field positions
    localparam int MODE_SEL_BIT    = 0;
    localparam int MODE_STATUS_BIT = 1;
    localparam int OSC_STOP_BIT    = 0;
    localparam int IRQ_STAB_BIT    = 0;
    localparam int IRQ_SWITCH_BIT  = 1;
    localparam int NUM_IRQ         = 2;
    // widths and reset values
    localparam int         NUM_STAB       = 5;
    localparam int         TSEL_W         = 3;
    localparam logic [2:0] TSEL_RESET     = 3'h4;
    localparam logic       MODE_SEL_RESET = 1'b0;
    localparam logic       OSC_STOP_RESET = 1'b0;
    // ring oscillator rate is a plain default, peripheral clock nominal
    localparam int RING_KHZ      = 480;
    localparam int PERIPH_KHZ    = 240;
    localparam int RING_DIV      = RING_KHZ / PERIPH_KHZ;
    localparam int STAB_LOG_BASE = 11;
    localparam int STAB_CNT_W    = 24;

    typedef enum logic [1:0] {
        ST_IDLE     = 2'b00,
        ST_WAIT_OSC = 2'b01,
        ST_COUNT    = 2'b11,
        ST_DONE     = 2'b10
    } stab_state_t;

    typedef struct packed {
        logic crystal;
        logic ring;
        logic osc_ok;
    } pin_sync_t;

    typedef struct packed {
        logic clk_switch;
        logic stab_done;
    } clk_event_t;

    function automatic logic [STAB_CNT_W-1:0] stab_threshold(input int log_base, input int idx);
        stab_threshold = STAB_CNT_W'(1) << (log_base + idx);
    endfunction
endpackage
`default_nettype wire

// File: design/ring_divider.sv
`timescale 1ns/1ps
`default_nettype none
module ring_divider
    import clk_ctrl_pkg::*;
#(
    parameter int DIV = RING_DIV
) (
    // clock and reset
    input  wire logic i_mclk,
    input  wire logic i_reset_n,
    // ring edges in
    input  wire logic i_edge,
    // divided tick out
    output logic      o_tick
);
    localparam int CW = $clog2(DIV + 1);
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] cnt_reg;

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            cnt_reg <= '0;
        end else if (i_edge) begin
            cnt_reg <= (cnt_reg == LAST) ? '0 : cnt_reg + CW'(1);
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            o_tick <= 1'b0;
        end else begin
            o_tick <= i_edge && (cnt_reg == LAST);
        end
    end
endmodule // ring_divider
`default_nettype wire

// File: design/stab_counter.sv
`timescale 1ns/1ps
`default_nettype none
module stab_counter
    import clk_ctrl_pkg::*;
#(
    parameter int LOG_BASE = STAB_LOG_BASE
) (
    // clock and reset
    input  wire logic                i_mclk,
    input  wire logic                i_reset_n,
    // stop mode control
    input  wire logic                i_stop_enter,
    input  wire logic                i_stop_release,
    input  wire logic                i_osc_ok,
    input  wire logic                i_xtal_edge,
    input  wire logic [TSEL_W-1:0]   i_tsel,
    // status
    output logic [NUM_STAB-1:0]      o_flags,
    output logic                     o_done
);
    stab_state_t           state_reg;
    logic [STAB_CNT_W-1:0] cnt_reg;
    logic [TSEL_W-1:0]     sel_reg;
    logic [STAB_CNT_W-1:0] limit;

    assign limit = stab_threshold(LOG_BASE, int'(sel_reg));

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            state_reg <= ST_WAIT_OSC;
        end else begin
            case (state_reg)
                ST_IDLE:     if (i_stop_release) state_reg <= ST_WAIT_OSC;
                // R08: wait excludes start-up
                ST_WAIT_OSC: if (i_osc_ok) state_reg <= ST_COUNT;
                ST_COUNT:    if (cnt_reg >= limit) state_reg <= ST_DONE;
                ST_DONE:     if (i_stop_enter) state_reg <= ST_IDLE;
                default:     state_reg <= ST_IDLE;
            endcase
        end
    end

    // selection latched so a later write cannot stretch the wait
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            sel_reg <= TSEL_RESET;
        end else if (state_reg == ST_IDLE || state_reg == ST_WAIT_OSC) begin
            sel_reg <= (i_tsel >= TSEL_W'(NUM_STAB)) ? TSEL_W'(NUM_STAB - 1) : i_tsel;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n || state_reg == ST_IDLE || state_reg == ST_WAIT_OSC) begin
            cnt_reg <= '0;
        // R06: count stops at selection
        end else if (state_reg == ST_COUNT && i_xtal_edge && cnt_reg < limit) begin
            cnt_reg <= cnt_reg + STAB_CNT_W'(1);
        end
    end

    // R05: flags set in order, stay set
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n || state_reg == ST_IDLE) begin
            o_flags <= '0;
        end else begin
            for (int i = 0; i < NUM_STAB; i++) begin
                if (cnt_reg >= stab_threshold(LOG_BASE, i) && TSEL_W'(i) <= sel_reg) begin
                    o_flags[i] <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            o_done <= 1'b0;
        end else begin
            o_done <= (state_reg == ST_COUNT) && (cnt_reg >= limit);
        end
    end

    // R05: flags never clear while counting
    flags_sticky_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // R05
        (state_reg != ST_IDLE && $past(state_reg) != ST_IDLE) |-> ((o_flags & $past(o_flags)) == $past(o_flags)))
        else $error("stabilization flag dropped");
    // R05: lower flag always set first
    flags_order_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // R05
        ((o_flags & (o_flags + NUM_STAB'(1))) == '0))
        else $error("stabilization flags out of order");
    // R06: nothing beyond selection
    sel_limit_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // R06
        (cnt_reg <= limit) && ((o_flags >> (int'(sel_reg) + 1)) == '0))
        else $error("count past selected time");
    // R08: no count before oscillation
    osc_first_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // R08
        (state_reg == ST_WAIT_OSC) |=> (cnt_reg == '0))
        else $error("counted before oscillation");
    stab_done_c: cover property (@(posedge i_mclk) disable iff (!i_reset_n) o_done);
endmodule // stab_counter
`default_nettype wire

// File: design/clk_ctrl.sv
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R01: ring selected: peripherals get divided ring clock
// R02: software halts peripherals before ring switch
// R03: only listed peripherals used on ring
// R04: software checks select status zero before stop
// R05: status bits set in order, stay set
// R06: counter stops at selected stabilization time
// R07: software selects time no shorter than wanted
// R08: wait counted only after oscillation begins
module clk_ctrl
    import clk_ctrl_pkg::*;
#(
    parameter int LOG_BASE = STAB_LOG_BASE,
    parameter int DIV      = RING_DIV
) (
    // clock and reset
    input  wire logic                i_mclk,
    input  wire logic                i_reset_n,
    // apb slave
    input  wire logic                i_psel,
    input  wire logic                i_penable,
    input  wire logic                i_pwrite,
    input  wire logic [7:0]          i_paddr,
    input  wire logic [31:0]         i_pwdata,
    output logic [31:0]              o_prdata,
    output logic                     o_pready,
    output logic                     o_pslverr,
    // oscillator pins
    input  wire logic                i_crystal_clock_input,
    input  wire logic                i_internal_ring_oscillator,
    input  wire logic                i_osc_running,
    // stop mode from the cpu core
    input  wire logic                i_stop_enter,
    input  wire logic                i_stop_release,
    // clock outputs
    output logic                     o_cpu_on_crystal,
    output logic                     o_peripheral_base_clock,
    output logic                     o_main_osc_stop,
    output logic [NUM_STAB-1:0]      o_stab_flags,
    // interrupt
    output logic                     o_irq
);
    pin_sync_t             meta_reg;
    pin_sync_t             sync_reg;
    pin_sync_t             prev_reg;
    logic                  xtal_edge;
    logic                  ring_edge;
    logic                  ring_tick;
    logic                  main_clock_mode_reg;
    logic                  main_clock_select_status;
    logic                  main_osc_control_reg;
    logic [TSEL_W-1:0]     stabilization_time_select;
    logic [NUM_STAB-1:0]   stabilization_status_reg;
    logic                  stab_done;
    logic [NUM_IRQ-1:0]    irq_status_reg;
    logic [NUM_IRQ-1:0]    irq_mask_reg;
    clk_event_t            events;
    logic                  setup;
    logic                  wr_access;
    logic                  mapped;
    logic                  select_next;
    logic [31:0]           rd_word;
    localparam int               GAP_W    = $clog2(DIV + 1);
    localparam logic [GAP_W-1:0] GAP_FULL = GAP_W'(DIV);
    logic [GAP_W-1:0]      ring_gap_reg;

    // pin synchronisers; edges only from the second stage
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            meta_reg <= '0;
            sync_reg <= '0;
            prev_reg <= '0;
        end else begin
            meta_reg <= '{i_crystal_clock_input, i_internal_ring_oscillator, i_osc_running};
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    // crystal must be well below mclk/2 to be seen edge by edge
    assign xtal_edge = sync_reg.crystal & ~prev_reg.crystal;
    assign ring_edge = sync_reg.ring & ~prev_reg.ring;

    ring_divider #(
        .DIV (DIV)
    ) u_ring_div (
        .i_mclk    (i_mclk),
        .i_reset_n (i_reset_n),
        .i_edge    (ring_edge),
        .o_tick    (ring_tick)
    );

    // ring edges since the last divided tick, kept apart from the divider for the ratio check
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            ring_gap_reg <= '0;
        end else if (ring_tick) begin
            ring_gap_reg <= ring_edge ? GAP_W'(1) : '0;
        end else if (ring_edge) begin
            ring_gap_reg <= ring_gap_reg + GAP_W'(1);
        end
    end

    stab_counter #(
        .LOG_BASE (LOG_BASE)
    ) u_stab (
        .i_mclk         (i_mclk),
        .i_reset_n      (i_reset_n),
        .i_stop_enter   (i_stop_enter),
        .i_stop_release (i_stop_release),
        .i_osc_ok       (sync_reg.osc_ok && !main_osc_control_reg),
        .i_xtal_edge    (xtal_edge),
        .i_tsel         (stabilization_time_select),
        .o_flags        (stabilization_status_reg),
        .o_done         (stab_done)
    );

    // apb decode, zero wait states
    assign setup     = i_psel & ~i_penable;
    assign wr_access = i_psel & i_penable & i_pwrite & ~o_pslverr;
    assign o_pready  = 1'b1;

    always_comb begin
        case (i_paddr)
            ADDR_MODE, ADDR_OSC, ADDR_TSEL,
            ADDR_STAB, ADDR_IRQ, ADDR_MASK: mapped = 1'b1;
            default:                         mapped = 1'b0;
        endcase
    end

    assign o_pslverr = i_psel & i_penable & ~mapped;

    always_comb begin
        rd_word = '0;
        case (i_paddr)
            ADDR_MODE: begin
                rd_word[MODE_SEL_BIT]    = main_clock_mode_reg;
                rd_word[MODE_STATUS_BIT] = main_clock_select_status;
            end
            ADDR_OSC:  rd_word[OSC_STOP_BIT]       = main_osc_control_reg;
            ADDR_TSEL: rd_word[TSEL_W-1:0]         = stabilization_time_select;
            ADDR_STAB: rd_word[NUM_STAB-1:0]       = stabilization_status_reg;
            ADDR_IRQ:  rd_word[NUM_IRQ-1:0]        = irq_status_reg;
            ADDR_MASK: rd_word[NUM_IRQ-1:0]        = irq_mask_reg;
            default:   rd_word = '0;
        endcase
    end

    // read data caught in setup so it comes from a flop
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            o_prdata <= '0;
        end else if (setup && !i_pwrite) begin
            o_prdata <= rd_word;
        end
    end

    // software clock select request
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            main_clock_mode_reg <= MODE_SEL_RESET;
        end else if (wr_access && i_paddr == ADDR_MODE) begin
            main_clock_mode_reg <= i_pwdata[MODE_SEL_BIT];
        end
    end

    // crystal only taken once stabilization flag 0 is set and the stop bit is clear
    assign select_next = main_clock_mode_reg && stab_done_seen() && !main_osc_control_reg;

    function automatic logic stab_done_seen();
        stab_done_seen = stabilization_status_reg[0];
    endfunction

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            main_clock_select_status <= 1'b0;
        end else begin
            main_clock_select_status <= select_next;
        end
    end

    // stop request ignored while the cpu still runs on the crystal
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            main_osc_control_reg <= OSC_STOP_RESET;
        end else if (wr_access && i_paddr == ADDR_OSC) begin
            main_osc_control_reg <= i_pwdata[OSC_STOP_BIT] & ~main_clock_select_status;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            stabilization_time_select <= TSEL_RESET;
        end else if (wr_access && i_paddr == ADDR_TSEL) begin
            stabilization_time_select <= i_pwdata[TSEL_W-1:0];
        end
    end

    // R01: peripheral clock source
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            o_peripheral_base_clock <= 1'b0;
        end else begin
            o_peripheral_base_clock <= main_clock_select_status ? xtal_edge : ring_tick;
        end
    end

    assign o_cpu_on_crystal = main_clock_select_status;
    assign o_main_osc_stop  = main_osc_control_reg;
    assign o_stab_flags     = stabilization_status_reg;

    // interrupt events
    assign events.stab_done  = stab_done;
    assign events.clk_switch = main_clock_select_status ^ select_next;

    // set wins over a write-one clear in the same cycle
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            irq_status_reg <= '0;
        end else begin
            irq_status_reg <= (irq_status_reg
                               & ~((wr_access && i_paddr == ADDR_IRQ) ? i_pwdata[NUM_IRQ-1:0] : '0))
                              | events;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            irq_mask_reg <= '0;
        end else if (wr_access && i_paddr == ADDR_MASK) begin
            irq_mask_reg <= i_pwdata[NUM_IRQ-1:0];
        end
    end

    assign o_irq = |(irq_status_reg & irq_mask_reg);

    // R01: ring mode ticks come from divider
    ring_tick_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // R01
        (!main_clock_select_status && ring_tick) |=> o_peripheral_base_clock)
        else $error("ring tick not passed to peripherals");
    // R01: no crystal ticks while on ring
    ring_only_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // R01
        ($past(!main_clock_select_status) && o_peripheral_base_clock) |-> $past(ring_tick))
        else $error("peripheral tick without ring tick");
    // R08: crystal selection only after stable start
    xtal_ready_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // R08
        $rose(main_clock_select_status) |-> $past(stabilization_status_reg[0]))
        else $error("crystal selected before stable");
    irq_sticky_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        events.stab_done |=> irq_status_reg[IRQ_STAB_BIT])
        else $error("stabilization event lost");
    // R01: ring divided by the set ratio
    ring_ratio_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n) // R01
        ring_tick |-> (ring_gap_reg == GAP_FULL))
        else $error("ring divide ratio wrong");
    // stop bit taken only while on the ring
    stop_write_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        (wr_access && i_paddr == ADDR_OSC && !main_clock_select_status)
        |=> (main_osc_control_reg == $past(i_pwdata[OSC_STOP_BIT])))
        else $error("stop bit write lost");
    stop_refused_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        (wr_access && i_paddr == ADDR_OSC && main_clock_select_status) |=> !main_osc_control_reg)
        else $error("stop bit taken on crystal");
    // crystal released once any condition fails
    select_drop_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        (!main_clock_mode_reg || main_osc_control_reg || !stabilization_status_reg[0])
        |=> !main_clock_select_status)
        else $error("crystal kept after condition lost");
    // register writes land at the access edge
    mode_write_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        (wr_access && i_paddr == ADDR_MODE) |=> (main_clock_mode_reg == $past(i_pwdata[MODE_SEL_BIT])))
        else $error("mode write lost");
    tsel_write_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        (wr_access && i_paddr == ADDR_TSEL) |=> (stabilization_time_select == $past(i_pwdata[TSEL_W-1:0])))
        else $error("time select write lost");
    mask_write_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        (wr_access && i_paddr == ADDR_MASK) |=> (irq_mask_reg == $past(i_pwdata[NUM_IRQ-1:0])))
        else $error("mask write lost");
    // unmapped writes leave the mode, stop, time select and mask registers alone
    unmapped_write_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        (i_psel && i_penable && i_pwrite && !mapped)
        |=> ($stable(main_clock_mode_reg) && $stable(main_osc_control_reg)
             && $stable(stabilization_time_select) && $stable(irq_mask_reg)))
        else $error("unmapped write changed a register");
    // read word captured in setup
    read_capture_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        (i_psel && !i_penable && !i_pwrite) |=> (o_prdata == $past(rd_word)))
        else $error("read data not captured");
    // write-one clear and switch event
    irq_clear_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        (wr_access && i_paddr == ADDR_IRQ && i_pwdata[IRQ_STAB_BIT] && !events.stab_done)
        |=> !irq_status_reg[IRQ_STAB_BIT])
        else $error("stabilization status not cleared");
    switch_event_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        events.clk_switch |=> irq_status_reg[IRQ_SWITCH_BIT])
        else $error("switch event lost");

    switch_c:  cover property (@(posedge i_mclk) disable iff (!i_reset_n) $rose(main_clock_select_status));
    back_c:    cover property (@(posedge i_mclk) disable iff (!i_reset_n) $fell(main_clock_select_status));
    irq_c:     cover property (@(posedge i_mclk) disable iff (!i_reset_n) o_irq);
    stop_c:    cover property (@(posedge i_mclk) disable iff (!i_reset_n) $rose(main_osc_control_reg));
endmodule // clk_ctrl
`default_nettype wire

// File: verification/clk_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module clk_ctrl_tb;
    import clk_ctrl_pkg::*;
    // small counts keep the run short
    localparam int LB = 2;
    localparam int DV = 2;
    logic                i_mclk = 1'b0;
    logic                i_reset_n = 1'b0;
    logic                i_psel = 1'b0;
    logic                i_penable = 1'b0;
    logic                i_pwrite = 1'b0;
    logic [7:0]          i_paddr = 8'h00;
    logic [31:0]         i_pwdata = 32'h0;
    logic                i_xtal = 1'b0;
    logic                i_ring = 1'b0;
    logic                i_osc_running = 1'b0;
    logic                i_stop_enter = 1'b0;
    logic                i_stop_release = 1'b0;
    logic [31:0]         o_prdata;
    logic                o_pready;
    logic                o_pslverr;
    logic                o_cpu_on_crystal;
    logic                o_peripheral_base_clock;
    logic                o_main_osc_stop;
    logic [NUM_STAB-1:0] o_stab_flags;
    logic                o_irq;
    logic [NUM_STAB-1:0] prev = '0;
    logic                mon_on = 1'b0;
    int                  n_mismatch = 0;
    int                  samples_checked = 0;
    int                  xc = 0;
    int                  rc = 0;
    int                  x_edges = 0;
    int                  r_edges = 0;
    int                  ticks = 0;

    clk_ctrl #(.LOG_BASE(LB), .DIV(DV)) u_dut (
        .i_mclk(i_mclk), .i_reset_n(i_reset_n),
        .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
        .i_paddr(i_paddr), .i_pwdata(i_pwdata),
        .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
        .i_crystal_clock_input(i_xtal), .i_internal_ring_oscillator(i_ring),
        .i_osc_running(i_osc_running),
        .i_stop_enter(i_stop_enter), .i_stop_release(i_stop_release),
        .o_cpu_on_crystal(o_cpu_on_crystal), .o_peripheral_base_clock(o_peripheral_base_clock),
        .o_main_osc_stop(o_main_osc_stop), .o_stab_flags(o_stab_flags), .o_irq(o_irq));

    always #12.5 i_mclk = ~i_mclk;

    // slow pins: high phases at least three mclk periods
    always @(posedge i_mclk) begin
        xc <= (xc == 2) ? 0 : xc + 1;
        rc <= (rc == 3) ? 0 : rc + 1;
        if (xc == 2) begin
            i_xtal <= ~i_xtal;
            if (!i_xtal) x_edges <= x_edges + 1;
        end
        if (rc == 3) begin
            i_ring <= ~i_ring;
            if (!i_ring) r_edges <= r_edges + 1;
        end
        if (o_peripheral_base_clock === 1'b1) ticks <= ticks + 1;
    end

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wrap_up();
        if (n_mismatch == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // flags form a growing thermometer, none ever drops
    always @(posedge i_mclk) begin
        if (mon_on)
            check("stab_order", {31'h0, ((o_stab_flags + 5'h1) & o_stab_flags) === 5'h0
                                 && (o_stab_flags & prev) === prev}, 32'h1);
        prev <= mon_on ? o_stab_flags : '0;
    end

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge i_mclk);
        i_psel    <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite  <= wr;
        i_paddr   <= a;
        i_pwdata  <= wd;
        @(posedge i_mclk);
        i_penable <= 1'b1;
        n = 0;
        do begin
            @(posedge i_mclk);
            n++;
        end while (o_pready !== 1'b1 && n < 50);
        rd = o_prdata;
        err = o_pslverr;
        if (n >= 50) n_mismatch++;
        i_psel    <= 1'b0;
        i_penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        e;
        apb(1'b1, a, d, rd, e);
    endtask

    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        logic        e;
        apb(1'b0, a, 32'h0, rd, e);
        check(nm, rd, exp);
    endtask

    task automatic wait_flag(input int idx);
        int n;
        n = 0;
        while (o_stab_flags[idx] !== 1'b1 && n < 3000) begin
            @(posedge i_mclk);
            n++;
        end
        check("stab_wait", {31'h0, n < 3000}, 32'h1);
    endtask

    // peripheral ticks against counted source edges over a fixed window
    task automatic measure(input bit on_xtal);
        int t0;
        int e0;
        int d;
        int ex;
        t0 = ticks;
        e0 = on_xtal ? x_edges : r_edges;
        repeat (600) @(posedge i_mclk);
        ex = ((on_xtal ? x_edges : r_edges) - e0) / (on_xtal ? 1 : DV);
        d = ticks - t0 - ex;
        check("periph_ticks", {31'h0, d <= 1 && d >= -1}, 32'h1);
    endtask

    task automatic pulse(input bit rel);
        @(posedge i_mclk);
        if (rel) i_stop_release <= 1'b1;
        else i_stop_enter <= 1'b1;
        @(posedge i_mclk);
        i_stop_release <= 1'b0;
        i_stop_enter   <= 1'b0;
    endtask

    initial begin
        int sel;
        int s;
        logic [31:0] rd;
        logic        e;
        sel = $urandom(32'hcdc9);
        repeat (10) @(posedge i_mclk);
        i_reset_n <= 1'b1;
        rdchk("tsel_reset", ADDR_TSEL, 32'h4);
        rdchk("mask_reset", ADDR_MASK, 32'h0);
        rdchk("mode_reset", ADDR_MODE, 32'h0);
        apb(1'b0, 8'h18, 32'h0, rd, e);
        check("unmapped_err", {31'h0, e}, 32'h1);
        check("unmapped_data", rd, 32'h0);
        wr(8'h18, 32'hffff_ffff);
        repeat (100) @(posedge i_mclk);
        check("flags_idle", {27'h0, o_stab_flags}, 32'h0);
        mon_on <= 1'b1;
        i_osc_running <= 1'b1;
        wait_flag(4);
        repeat (20) @(posedge i_mclk);
        rdchk("stab_all", ADDR_STAB, 32'h1f);
        // only the divided tick is used on ring
        measure(1'b0);
        // select status read as zero first
        rdchk("mode_ring", ADDR_MODE, 32'h0);
        wr(ADDR_OSC, 32'h1);
        rdchk("stop_set", ADDR_OSC, 32'h1);
        check("stop_pin", {31'h0, o_main_osc_stop}, 32'h1);
        wr(ADDR_OSC, 32'h0);
        wr(ADDR_MODE, 32'h1);
        repeat (4) @(posedge i_mclk);
        rdchk("mode_xtal", ADDR_MODE, 32'h3);
        check("on_xtal", {31'h0, o_cpu_on_crystal}, 32'h1);
        measure(1'b1);
        // stop request refused while the cpu runs on crystal
        wr(ADDR_OSC, 32'h1);
        rdchk("stop_refused", ADDR_OSC, 32'h0);
        check("stop_pin_off", {31'h0, o_main_osc_stop}, 32'h0);
        rdchk("irq_stat", ADDR_IRQ, 32'h3);
        check("irq_masked", {31'h0, o_irq}, 32'h0);
        wr(ADDR_MASK, 32'h3);
        repeat (2) @(posedge i_mclk);
        check("irq_on", {31'h0, o_irq}, 32'h1);
        wr(ADDR_IRQ, 32'h3);
        rdchk("irq_clr", ADDR_IRQ, 32'h0);
        check("irq_off", {31'h0, o_irq}, 32'h0);
        wr(ADDR_MASK, 32'h0);
        // no peripheral use before ring switch
        wr(ADDR_MODE, 32'h0);
        repeat (4) @(posedge i_mclk);
        check("on_ring", {31'h0, o_cpu_on_crystal}, 32'h0);
        // random selections, values above 4 act as 4
        repeat (5) begin
            sel = $urandom % 8;
            s = (sel > 4) ? 4 : sel;
            wr(ADDR_TSEL, sel);
            mon_on <= 1'b0;
            pulse(1'b0);
            i_osc_running <= 1'b0;
            repeat (3) @(posedge i_mclk);
            check("flags_clr", {27'h0, o_stab_flags}, 32'h0);
            pulse(1'b1);
            mon_on <= 1'b1;
            repeat (60) @(posedge i_mclk);
            check("flags_wait", {27'h0, o_stab_flags}, 32'h0);
            i_osc_running <= 1'b1;
            // wait only up to selected time
            wait_flag(s);
            repeat (300) @(posedge i_mclk);
            check("flags_sel", {27'h0, o_stab_flags}, (32'h1 << (s + 1)) - 32'h1);
        end
        wrap_up();
    end

    // hang guard well beyond the expected run length
    initial begin
        repeat (60000) @(posedge i_mclk);
        n_mismatch++;
        wrap_up();
    end
endmodule // clk_ctrl_tb
`default_nettype wire
